// [logic/fltf_bank.sv]
// Torch control and fault flag register bank of a dual LED flash driver.
`timescale 1ns/1ns
`include "fltf_regs.svh"
module fltf_bank
	import fltf_pkg::*;
(
	// Clock and reset.
	input wire logic clk,
	input wire logic rst_b,
	// Register port from the serial bus engine.
	input wire logic [7:0] reg_addr,
	input wire logic reg_wr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_rd,
	output logic [7:0] reg_rdata,
	// Host disable written over the bus elsewhere.
	input wire logic host_disable,
	// Hardware torch pin.
	input wire logic torch_pin,
	// Analog detector levels.
	input wire logic output_overvoltage_guard,
	input wire logic thermistor_trip_flag,
	input wire logic thermal_shutdown,
	input wire logic inductor_current_limit_event,
	input wire logic input_voltage_flash_monitor,
	input wire logic undervoltage_lockout,
	input wire logic output_short_flag,
	input wire logic flash_timeout,
	input wire logic second_led_channel_short,
	input wire logic first_led_channel_short,
	input wire logic thermistor_sense_low,
	input wire logic thermistor_sense_high,
	// Operating state and currents.
	output logic torch_on,
	output logic [6:0] first_led_channel_level,
	output logic [6:0] second_led_channel_level,
	output logic fault_shutdown,
	output logic op_halted
);
	localparam int NIN = 13;

	logic [NIN-1:0] raw_in;
	logic [NIN-1:0] syn;
	fltf_state_t s_q;
	fltf_state_t s_d;

	assign raw_in = {torch_pin, thermistor_sense_high, thermistor_sense_low,
		first_led_channel_short, second_led_channel_short, flash_timeout,
		output_short_flag, undervoltage_lockout,
		input_voltage_flash_monitor, inductor_current_limit_event,
		thermal_shutdown, thermistor_trip_flag, output_overvoltage_guard};

	fltf_sync #(
		.WIDTH(NIN)
	) u_sync (
		.clk(clk),
		.rst_b(rst_b),
		.din(raw_in),
		.dout(syn)
	);

	// Maps the three-bit-coarse maximum torch code onto the seven-bit scale.
	function automatic logic [6:0] max_to_lvl(input logic [2:0] m);
		max_to_lvl = {m, 4'hF};
	endfunction : max_to_lvl

	// Detector picture of the first flag register, bit 7 down to bit 0.
	function automatic logic [7:0] flag_a_now(input logic [NIN-1:0] v);
		flag_a_now = {v[0], v[1], v[2], v[3], v[4], v[5], v[6], v[7]};
	endfunction : flag_a_now

	logic [7:0] a_now;
	logic [7:0] b_now;
	logic rd_a;
	logic rd_b;
	logic [6:0] lvl;
	logic [6:0] mx;
	logic fault_any;

	always_comb begin
		s_d = s_q;
		a_now = flag_a_now(syn);
		b_now = 8'h00;
		b_now[`FLTF_B_SECOND_LED_CHANNEL_SHORT] = syn[8];
		b_now[`FLTF_B_FIRST_LED_CHANNEL_SHORT] = syn[9];
		b_now[`FLTF_B_TSHORT] = syn[10] & s_q.flag_b[`FLTF_B_TSHORT_EN];
		b_now[`FLTF_B_TOPEN] = syn[11];
		rd_a = reg_rd && (reg_addr == `FLTF_OFS_FLAGA);
		rd_b = reg_rd && (reg_addr == `FLTF_OFS_FLAGB);

		unique case (reg_addr)
			`FLTF_OFS_TORCH: s_d.rdata = s_q.torch;
			`FLTF_OFS_FLAGA: s_d.rdata = s_q.flag_a;
			`FLTF_OFS_FLAGB: s_d.rdata = s_q.flag_b & ~(8'h01 << `FLTF_B_RESERVED);
			default: s_d.rdata = 8'h00;
		endcase

		// Reads clear the first flag register and bits 1:0 of the second, but a condition still present sets again; set wins.
		if (rd_a) begin
			s_d.flag_a = 8'h00;
		end
		s_d.flag_a = s_d.flag_a | a_now;
		if (rd_b) begin
			s_d.flag_b = s_q.flag_b & ~`FLTF_B_RC_MASK;
		end
		s_d.flag_b = s_d.flag_b | b_now;

		if (reg_wr && reg_addr == `FLTF_OFS_TORCH) begin
			s_d.torch = reg_wdata;
		end
		if (reg_wr && reg_addr == `FLTF_OFS_MAX) begin
			s_d.max_torch = reg_wdata[6:4];
		end
		if (reg_wr && reg_addr == `FLTF_OFS_FLAGB) begin
			s_d.flag_b = (s_d.flag_b & ~`FLTF_B_WR_MASK)
				| (reg_wdata & `FLTF_B_WR_MASK);
		end

		// Faults halt operation when shutdown is enabled, or stop it while host disable is set.
		fault_any = (|(s_q.flag_a & `FLTF_FAULT_MASK))
			| (|s_q.flag_b[`FLTF_B_SECOND_LED_CHANNEL_SHORT:`FLTF_B_TSHORT]);
		unique case (s_q.run)
			FLTF_RUN: begin
				if (fault_any && s_q.flag_b[`FLTF_B_FSD_EN]) begin
					s_d.run = FLTF_HALT;
				end else if (fault_any && host_disable) begin
					s_d.run = FLTF_OFF;
				end
			end
			FLTF_HALT: begin
				if (rd_a) begin
					s_d.run = FLTF_RUN;
				end
			end
			FLTF_OFF: begin
				if (!host_disable) begin
					s_d.run = FLTF_RUN;
				end
			end
			default: s_d.run = FLTF_RUN;
		endcase
		s_d.shutdown = (s_d.run != FLTF_RUN);

		// Level mapping and split between the two LED channels.
		lvl = s_q.torch[6:0];
		mx = max_to_lvl(s_q.max_torch);
		s_d.torch_on = s_q.torch[`FLTF_TORCH_PIN_BIT] & syn[12]
			& (s_q.run == FLTF_RUN);
		if (lvl == `FLTF_LVL_OFF) begin
			s_d.first_led_channel_lvl = 7'h00;
			s_d.second_led_channel_lvl = mx;
		end else if (lvl == `FLTF_LVL_FULL) begin
			s_d.first_led_channel_lvl = mx;
			s_d.second_led_channel_lvl = 7'h00;
		end else if (mx < lvl) begin
			s_d.first_led_channel_lvl = mx;
			s_d.second_led_channel_lvl = 7'h00;
		end else begin
			s_d.first_led_channel_lvl = lvl;
			s_d.second_led_channel_lvl = mx - lvl;
		end

		// Software reset returns the registers and run state to defaults; the bit self-clears.
		if (reg_wr && reg_addr == `FLTF_OFS_FLAGB
			&& reg_wdata[`FLTF_B_SWRST]) begin
			s_d.torch = `FLTF_TORCH_RST;
			s_d.max_torch = `FLTF_MAX_RST;
			s_d.flag_a = 8'h00;
			s_d.flag_b = `FLTF_FLAGB_RST;
			s_d.run = FLTF_RUN;
			s_d.shutdown = 1'b0;
			s_d.torch_on = 1'b0;
		end
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			s_q.torch <= `FLTF_TORCH_RST;
			s_q.max_torch <= `FLTF_MAX_RST;
			s_q.flag_a <= 8'h00;
			s_q.flag_b <= `FLTF_FLAGB_RST;
			s_q.rdata <= 8'h00;
			s_q.run <= FLTF_RUN;
			s_q.torch_on <= 1'b0;
			s_q.first_led_channel_lvl <= 7'h00;
			s_q.second_led_channel_lvl <= 7'h00;
			s_q.shutdown <= 1'b0;
		end else begin
			s_q <= s_d;
		end
	end

	assign reg_rdata = s_q.rdata;
	assign torch_on = s_q.torch_on;
	assign first_led_channel_level = s_q.first_led_channel_lvl;
	assign second_led_channel_level = s_q.second_led_channel_lvl;
	assign fault_shutdown = s_q.shutdown;
	assign op_halted = s_q.shutdown;
endmodule : fltf_bank

// [inc/fltf_regs.svh]
// Register offsets, field positions, reset values and timing for the flag bank.
`ifndef FLTF_REGS_SVH
`define FLTF_REGS_SVH
`define FLTF_OFS_MAX 8'h05
`define FLTF_OFS_TORCH 8'h07
`define FLTF_OFS_FLAGA 8'h08
`define FLTF_OFS_FLAGB 8'h09
`define FLTF_TORCH_RST 8'h00
`define FLTF_MAX_RST 3'h7
`define FLTF_FLAGB_RST 8'h30
`define FLTF_TORCH_PIN_BIT 7
`define FLTF_LVL_OFF 7'h00
`define FLTF_LVL_FULL 7'h7F
`define FLTF_B_RESERVED 7
`define FLTF_B_SWRST 6
`define FLTF_B_FSD_EN 5
`define FLTF_B_TSHORT_EN 4
`define FLTF_B_SECOND_LED_CHANNEL_SHORT 3
`define FLTF_B_FIRST_LED_CHANNEL_SHORT 2
`define FLTF_B_TSHORT 1
`define FLTF_B_TOPEN 0
`define FLTF_FAULT_MASK 8'hE7
`define FLTF_B_WR_MASK 8'h70
`define FLTF_B_RC_MASK 8'h03
`define FLTF_SYNC_STAGES 3
`endif

// [inc/fltf_pkg.sv]
// Types shared by the flag bank design.
package fltf_pkg;
	typedef enum logic [1:0] {
		FLTF_RUN = 2'b00,
		FLTF_HALT = 2'b01,
		FLTF_OFF = 2'b10
	} fltf_run_t;

	typedef struct packed {
		logic [7:0] torch;
		logic [2:0] max_torch;
		logic [7:0] flag_a;
		logic [7:0] flag_b;
		logic [7:0] rdata;
		fltf_run_t run;
		logic torch_on;
		logic [6:0] first_led_channel_lvl;
		logic [6:0] second_led_channel_lvl;
		logic shutdown;
	} fltf_state_t;
endpackage : fltf_pkg

// [logic/fltf_sync.sv]
// Three-stage input synchroniser; a change counts once stages two and three agree.
`timescale 1ns/1ns
module fltf_sync #(
	parameter int WIDTH = 16
) (
	// Clock and reset.
	input wire logic clk,
	input wire logic rst_b,
	// Raw and filtered levels.
	input wire logic [WIDTH-1:0] din,
	output logic [WIDTH-1:0] dout
);
	logic [WIDTH-1:0] s1_q;
	logic [WIDTH-1:0] s2_q;
	logic [WIDTH-1:0] s3_q;
	logic [WIDTH-1:0] out_q;

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			s1_q <= '0;
			s2_q <= '0;
			s3_q <= '0;
			out_q <= '0;
		end else begin
			s1_q <= din;
			s2_q <= s1_q;
			s3_q <= s2_q;
			for (int i = 0; i < WIDTH; i++) begin
				if (s2_q[i] == s3_q[i]) begin
					out_q[i] <= s3_q[i];
				end
			end
		end
	end

	assign dout = out_q;
endmodule : fltf_sync

// [verif/fltf_bank_checker.sv]
// Port-level assertions for the flag register bank.
`timescale 1ns/1ns
module fltf_bank_checker (
	// Clock and reset.
	input wire logic clk,
	input wire logic rst_b,
	// Register port and pins.
	input wire logic [7:0] reg_addr,
	input wire logic reg_wr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_rd,
	input wire logic [7:0] reg_rdata,
	input wire logic host_disable,
	input wire logic torch_pin,
	// State outputs.
	input wire logic torch_on,
	input wire logic fault_shutdown,
	input wire logic op_halted
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_b);
	sequence swrst_s;
		reg_wr && reg_addr == 8'h09 && reg_wdata[6];
	endsequence
	resv_bit_zero_a: assert property (
		$past(reg_addr) == 8'h09 |-> !reg_rdata[7]) else $error("rsv bit");
	swrst_defaults_a: assert property (
		swrst_s ##1 reg_addr == 8'h09 |=> reg_rdata[7:4] == 4'h3)
		else $error("swrst value");
	flagb_readback_a: assert property (
		reg_wr && reg_addr == 8'h09 && !reg_wdata[6] ##1 reg_addr == 8'h09
		|=> reg_rdata[6:4] == $past(reg_wdata[6:4], 2)) else $error("flagb");
	torch_readback_a: assert property (
		reg_wr && reg_addr == 8'h07 ##1 reg_addr == 8'h07
		|=> reg_rdata == $past(reg_wdata, 2)) else $error("torch rb");
	halt_release_a: assert property (
		$fell(fault_shutdown) |-> $past(reg_rd | reg_wr | host_disable)
		|| $past(reg_rd | reg_wr | host_disable, 2)) else $error("release");
	halt_mirror_a: assert property (
		fault_shutdown == op_halted) else $error("halt mirror");
	halt_torch_off_a: assert property (
		op_halted |=> !torch_on) else $error("torch while halted");
	swrst_torch_a: assert property (
		swrst_s |-> ##2 !torch_on) else $error("swrst torch");
	torch_pin_a: assert property (
		$rose(torch_on) |-> $past(torch_pin, 4) || $past(torch_pin, 5))
		else $error("torch pin");
	cover property (swrst_s);
	cover property ($rose(fault_shutdown));
	cover property ($rose(torch_on));
endmodule : fltf_bank_checker
bind fltf_bank fltf_bank_checker chk_u (.clk, .rst_b, .reg_addr, .reg_wr,
	.reg_wdata, .reg_rd, .reg_rdata, .host_disable, .torch_pin, .torch_on,
	.fault_shutdown, .op_halted);

// [verif/fltf_host.sv]
// Host model driving the bank's register port.
`timescale 1ns/1ns
module fltf_host (
	// Clock.
	input wire logic clk,
	// Register port.
	output logic [7:0] reg_addr,
	output logic reg_wr,
	output logic [7:0] reg_wdata,
	output logic reg_rd,
	input wire logic [7:0] reg_rdata
);
	initial begin
		reg_addr = 8'h00;
		reg_wr = 1'b0;
		reg_wdata = 8'h00;
		reg_rd = 1'b0;
	end
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		#10;
		reg_addr = a;
		reg_wdata = d;
		reg_wr = 1'b1;
		@(posedge clk);
		#10;
		reg_wr = 1'b0;
		reg_wdata = ~d;
	endtask : wr
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge clk);
		#10;
		reg_addr = a;
		reg_rd = 1'b1;
		@(posedge clk);
		#10;
		reg_rd = 1'b0;
		d = reg_rdata;
	endtask : rd
endmodule : fltf_host

// [verif/test_flash_led_torch_and_fault_flags.sv]
// Self-checking bench for the flag register bank.
`timescale 1ns/1ns
module test_flash_led_torch_and_fault_flags;
	logic clk = 1'b0;
	logic rst_b = 1'b0;
	logic host_disable = 1'b0;
	logic torch_pin = 1'b0;
	logic [7:0] det_a = 8'h00;
	logic [3:0] det_b = 4'h0;
	logic [7:0] reg_addr, reg_wdata, reg_rdata, rv, m;
	logic reg_wr, reg_rd, torch_on, fault_shutdown, op_halted;
	logic [6:0] lvl1, lvl2;
	int num_errors = 0;
	int checks_done = 0;
	int cycles = 0;
	initial forever #50 clk = ~clk;
	fltf_host host_u (.clk, .reg_addr, .reg_wr, .reg_wdata, .reg_rd,
		.reg_rdata);
	fltf_bank dut_u (.clk, .rst_b, .reg_addr, .reg_wr, .reg_wdata, .reg_rd,
		.reg_rdata, .host_disable, .torch_pin,
		.output_overvoltage_guard(det_a[7]), .thermistor_trip_flag(det_a[6]),
		.thermal_shutdown(det_a[5]), .inductor_current_limit_event(det_a[4]),
		.input_voltage_flash_monitor(det_a[3]),
		.undervoltage_lockout(det_a[2]), .output_short_flag(det_a[1]),
		.flash_timeout(det_a[0]), .second_led_channel_short(det_b[3]),
		.first_led_channel_short(det_b[2]), .thermistor_sense_low(det_b[1]),
		.thermistor_sense_high(det_b[0]), .torch_on,
		.first_led_channel_level(lvl1), .second_led_channel_level(lvl2),
		.fault_shutdown, .op_halted);
	task automatic complete_run();
		$display("checks %0d errors %0d", checks_done, num_errors);
		if (num_errors == 0 && checks_done > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : complete_run
	task automatic chk(input logic [7:0] e, input logic [7:0] a);
		checks_done++;
		if (a !== e) begin
			num_errors++;
			$display("CHECK FAILED t=%0t exp=%h got=%h", $time, e, a);
		end
	endtask : chk
	task automatic rchk(input logic [7:0] a, input logic [7:0] e);
		host_u.rd(a, rv);
		chk(e, rv);
	endtask : rchk
	task automatic waitc(input int n);
		repeat (n) @(posedge clk);
		#10;
	endtask : waitc
	always @(posedge clk) begin
		cycles++;
		if (cycles == 5000) begin
			num_errors++;
			complete_run();
		end
	end
	initial begin
		waitc(3);
		rst_b = 1'b1;
		rchk(8'h07, 8'h00);
		rchk(8'h08, 8'h00);
		rchk(8'h09, 8'h30);
		rchk(8'h0A, 8'h00);
		host_u.wr(8'h07, 8'h85);
		rchk(8'h07, 8'h85);
		waitc(6);
		chk(8'h0A, {lvl1, torch_on});
		chk(8'h7A, {1'b0, lvl2});
		torch_pin = 1'b1;
		waitc(6);
		chk(8'h01, {7'h00, torch_on});
		host_u.wr(8'h07, 8'h00);
		waitc(2);
		chk(8'h00, {lvl1, torch_on});
		chk(8'h7F, {1'b0, lvl2});
		host_u.wr(8'h07, 8'h7F);
		waitc(2);
		chk(8'hFE, {lvl1, torch_on});
		chk(8'h00, {1'b0, lvl2});
		torch_pin = 1'b0;
		for (int i = 0; i < 8; i++) begin
			m = 8'h01 << i;
			det_a = m;
			waitc(8);
			det_a = 8'h00;
			waitc(8);
			chk({7'h00, |(m & 8'hE7)}, {7'h00, fault_shutdown});
			chk({7'h00, |(m & 8'hE7)}, {7'h00, op_halted});
			rchk(8'h08, m);
			waitc(2);
			chk(8'h00, {7'h00, fault_shutdown});
			rchk(8'h08, 8'h00);
		end
		// A condition still present when the flags are read sets them again.
		det_a = 8'h10;
		waitc(8);
		rchk(8'h08, 8'h10);
		rchk(8'h08, 8'h10);
		det_a = 8'h00;
		waitc(8);
		rchk(8'h08, 8'h10);
		rchk(8'h08, 8'h00);
		for (int i = 0; i < 4; i++) begin
			m = 8'h01 << i;
			det_b = m[3:0];
			waitc(8);
			det_b = 4'h0;
			waitc(8);
			rchk(8'h09, 8'h30 | m);
			rchk(8'h09, (i < 2) ? 8'h30 : (8'h30 | m));
			host_u.wr(8'h09, 8'h40);
			rchk(8'h09, 8'h30);
			rchk(8'h08, 8'h00);
		end
		host_u.wr(8'h09, 8'h80);
		rchk(8'h09, 8'h00);
		det_b = 4'h2;
		det_a = 8'h80;
		waitc(8);
		det_b = 4'h0;
		det_a = 8'h00;
		waitc(8);
		chk(8'h00, {7'h00, fault_shutdown});
		rchk(8'h09, 8'h00);
		host_disable = 1'b1;
		waitc(2);
		chk(8'h01, {7'h00, fault_shutdown});
		chk(8'h01, {7'h00, op_halted});
		host_disable = 1'b0;
		rchk(8'h08, 8'h80);
		host_u.wr(8'h08, 8'hFF);
		rchk(8'h08, 8'h00);
		// A maximum code of 2 gives a maximum level of 0x2F.
		host_u.wr(8'h05, 8'h20);
		host_u.wr(8'h07, 8'h40);
		waitc(2);
		chk(8'h2F, {1'b0, lvl1});
		chk(8'h00, {1'b0, lvl2});
		host_u.wr(8'h07, 8'h10);
		waitc(2);
		chk(8'h10, {1'b0, lvl1});
		chk(8'h1F, {1'b0, lvl2});
		// A reset in mid-run restores the torch and maximum settings.
		rst_b = 1'b0;
		waitc(1);
		rst_b = 1'b1;
		waitc(1);
		chk(8'h7F, {1'b0, lvl2});
		rchk(8'h07, 8'h00);
		rchk(8'h09, 8'h30);
		complete_run();
	end
endmodule : test_flash_led_torch_and_fault_flags
